// File: rtl/accept_filter_cfg.svh
// register indices, field positions and reset values of the acceptance filter
// assumes: word-aligned APB, byte address = index * 4
`ifndef ACCEPT_FILTER_CFG_SVH
`define ACCEPT_FILTER_CFG_SVH

// ==========================================
// register indices
`define IDX_ACC_CTRL  6'h0B
`define IDX_RSV_A     6'h0C
`define IDX_RSV_B     6'h0D
`define IDX_RX_ERR    6'h0E
`define IDX_TX_ERR    6'h0F
`define IDX_CODE_BASE 6'h10
`define IDX_MASK_BASE 6'h18
`define IDX_IRQ_STAT  6'h20
`define IDX_IRQ_MASK  6'h21

// ==========================================
// fields
`define MODE_LSB      4
`define HIT_LSB       0
`define STAT_ACCEPT   0
`define STAT_DROP     1

// ==========================================
// reset values
`define MODE_RST      2'h0
`define HIT_RST       3'h0
`define IRQ_MASK_RST  2'h0
`define FILT_BYTE_RST 8'h00
`define RSV_READ      32'h0000_0000
`define CNT_RST       8'h00

`endif

// File: rtl/accept_filter_pkg.sv
// types of the acceptance filter; the byte store uses none of them
// assumes: nothing beyond the cfg header for numbers
package accept_filter_pkg;

   typedef enum logic [1:0] {
      MODE_32     = 2'b00,
      MODE_16     = 2'b01,
      MODE_8      = 2'b10,
      MODE_CLOSED = 2'b11
   } accept_mode_t;

   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b00,
      BUS_FETCH  = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_t;

endpackage : accept_filter_pkg

// File: rtl/filter_byte_store.sv
// sixteen code and mask bytes of the acceptance filter
// assumes: one write port from the bus, registered read port, all bytes visible
`timescale 1ns/100ps
`include "accept_filter_cfg.svh"

module filter_byte_store (
   input  wire logic         clock_in,
   input  wire logic         rst_in,
   input  wire logic         wr_en_in,
   input  wire logic [3:0]   wr_addr_in,
   input  wire logic [7:0]   wr_data_in,
   input  wire logic [3:0]   rd_addr_in,
   output logic      [7:0]   rd_data_out,
   output logic      [127:0] all_bytes_out
);

   logic [7:0] mem_q [16];

   always_ff @(posedge clock_in) begin
      rd_data_out <= mem_q[rd_addr_in];
   end

   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_byte
         always_ff @(posedge clock_in) begin
            if (rst_in) begin
               mem_q[g] <= `FILT_BYTE_RST;
            end else if (wr_en_in && wr_addr_in == 4'(g)) begin
               mem_q[g] <= wr_data_in;
            end
         end
         assign all_bytes_out[8*g +: 8] = mem_q[g];
      end
   endgenerate

endmodule : filter_byte_store

// File: rtl/accept_filter.sv
// identifier acceptance filter with error counter readout, APB slave
// assumes: frame inputs and mode handshakes come from logic on clock_in
`timescale 1ns/100ps
`include "accept_filter_cfg.svh"

// Function
// - mode code picks 32, 16, 8-bit or closed
// - closed mode never reloads foreground buffer
// - hit index is binary filter number
// - hit index follows foreground buffer frame
// - mode writable only in init mode
// - reserved test registers read zero
// - receive error count readable, read-only
// - transmit error count readable, writes ignored
// - frames land in background; accepted ones signalled
// - rejected frame overwritten, drop status flag set, no accept pulse
// - compare every identifier bit individually; code compares all 32 bits only for extended frames in 32-bit mode
// - in 32-bit mode extended uses four bytes, standard two; 16-bit mode uses two and 8-bit mode one for both
// - code byte compared, then qualified by mask
// - mask zero must match, one ignores
module accept_filter (
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        frame_valid_in,
   input  wire logic [31:0] frame_ident_in,
   input  wire logic        frame_extended_in,
   input  wire logic [7:0]  rx_err_count_in,
   input  wire logic [7:0]  tx_err_count_in,
   input  wire logic        init_request_in,
   input  wire logic        init_acknowledge_in,
   input  wire logic        sleep_request_in,
   input  wire logic        sleep_acknowledge_in,
   output logic             rx_accept_out,
   output logic [31:0]      rx_foreground_ident_out,
   output logic             rx_foreground_ext_out,
   output logic [2:0]       filter_hit_index_out,
   output logic             irq_out
);

   // ==========================================
   // functions
   function automatic logic byte_match(input logic [7:0] id, input logic [7:0] code,
                                       input logic [7:0] mask);
      byte_match = &(~(id ^ code) | mask);
   endfunction : byte_match

   function automatic logic [2:0] lowest_set(input logic [7:0] v);
      lowest_set = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            lowest_set = 3'(i);
         end
      end
   endfunction : lowest_set

   // ==========================================
   // state
   accept_filter_pkg::bus_state_t   bus_q;
   accept_filter_pkg::accept_mode_t mode_q;
   logic [31:0] bg_ident_q;
   logic        bg_ext_q;
   logic        eval_q;
   logic [1:0]  stat_q;
   logic [1:0]  stat_d;
   logic [1:0]  irq_mask_q;
   logic [7:0]  mem_rdata;
   logic [127:0] filt_bytes;
   logic [7:0]  rx_err_hold_q;
   logic [7:0]  tx_err_hold_q;

   // ==========================================
   // bus decode
   wire [5:0] idx        = paddr_in[7:2];
   wire       in_filt    = idx[5:4] == 2'b01;
   wire       init_mode  = init_request_in && init_acknowledge_in;
   wire       sleep_mode = sleep_request_in && sleep_acknowledge_in;
   wire       done       = bus_q == accept_filter_pkg::BUS_ANSWER && psel_in && penable_in;
   wire       wr_done    = done && pwrite_in;
   wire       rd_done    = done && !pwrite_in;
   wire       mapped     = in_filt || (idx >= `IDX_ACC_CTRL && idx <= `IDX_TX_ERR)
                           || idx == `IDX_IRQ_STAT || idx == `IDX_IRQ_MASK;
   wire       wr_mode    = wr_done && idx == `IDX_ACC_CTRL && init_mode;
   wire       clr_stat   = rd_done && idx == `IDX_IRQ_STAT;
   wire       count_mode = sleep_mode || init_mode;

   // counters move while the bus runs; software sees a copy taken in sleep or init
   // mode, so a read in any other mode returns the last such copy, not the live count
   wire [7:0] acc_ctrl_rd = {2'b00, mode_q, 1'b0, filter_hit_index_out};
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = `RSV_READ;
      if (in_filt) begin
         rd_mux = {24'h000000, mem_rdata};
      end else if (idx == `IDX_ACC_CTRL) begin
         rd_mux = {24'h000000, acc_ctrl_rd};
      end else if (idx == `IDX_RX_ERR) begin
         rd_mux = {24'h000000, rx_err_hold_q};
      end else if (idx == `IDX_TX_ERR) begin
         rd_mux = {24'h000000, tx_err_hold_q};
      end else if (idx == `IDX_IRQ_STAT) begin
         rd_mux = {30'h0, stat_q};
      end else if (idx == `IDX_IRQ_MASK) begin
         rd_mux = {30'h0, irq_mask_q};
      end
   end

   // ==========================================
   // error counter copies
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rx_err_hold_q <= `CNT_RST;
         tx_err_hold_q <= `CNT_RST;
      end else if (count_mode) begin
         rx_err_hold_q <= rx_err_count_in;
         tx_err_hold_q <= tx_err_count_in;
      end
   end

   // ==========================================
   // APB handshake: one wait cycle, then pready for one cycle
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         bus_q       <= accept_filter_pkg::BUS_IDLE;
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else begin
         unique case (bus_q)
            accept_filter_pkg::BUS_IDLE: begin
               pready_out <= 1'b0;
               if (psel_in && !penable_in) begin
                  bus_q <= accept_filter_pkg::BUS_FETCH;
               end
            end
            accept_filter_pkg::BUS_FETCH: begin
               bus_q       <= accept_filter_pkg::BUS_ANSWER;
               pready_out  <= 1'b1;
               prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
               pslverr_out <= !mapped;
            end
            accept_filter_pkg::BUS_ANSWER: begin
               bus_q       <= accept_filter_pkg::BUS_IDLE;
               pready_out  <= 1'b0;
               pslverr_out <= 1'b0;
            end
            default: begin
               bus_q      <= accept_filter_pkg::BUS_IDLE;
               pready_out <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================
   // code and mask bytes
   filter_byte_store u_store (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .wr_en_in      (wr_done && in_filt),
      .wr_addr_in    (idx[3:0]),
      .wr_data_in    (pwdata_in[7:0]),
      .rd_addr_in    (idx[3:0]),
      .rd_data_out   (mem_rdata),
      .all_bytes_out (filt_bytes)
   );

   // ==========================================
   // match network
   logic [7:0] code_b [8];
   logic [7:0] mask_b [8];
   logic [7:0] id_b   [4];
   logic [3:0] ok [8]; // ok[k][j]: code byte k against identifier byte j
   genvar k, j;
   generate
      for (k = 0; k < 8; k++) begin : g_code
         assign code_b[k] = filt_bytes[8*k +: 8];
         assign mask_b[k] = filt_bytes[8*(k+8) +: 8];
         for (j = 0; j < 4; j++) begin : g_id
            assign ok[k][j] = byte_match(id_b[j], code_b[k], mask_b[k]);
         end
      end
      for (j = 0; j < 4; j++) begin : g_idb
         assign id_b[j] = bg_ident_q[31-8*j -: 8];
      end
   endgenerate

   // standard frames leave the last two byte pairs out of a 32-bit filter
   wire [1:0] hit32;
   assign hit32[0] = ok[0][0] && ok[1][1] && (!bg_ext_q || (ok[2][2] && ok[3][3]));
   assign hit32[1] = ok[4][0] && ok[5][1] && (!bg_ext_q || (ok[6][2] && ok[7][3]));
   wire [3:0] hit16;
   generate
      for (k = 0; k < 4; k++) begin : g_h16
         assign hit16[k] = ok[2*k][0] && ok[2*k+1][1];
      end
   endgenerate
   wire [7:0] hit8 = {ok[7][0], ok[6][0], ok[5][0], ok[4][0],
                      ok[3][0], ok[2][0], ok[1][0], ok[0][0]};

   logic [7:0] hits;
   always_comb begin
      unique case (mode_q)
         accept_filter_pkg::MODE_32:     hits = {6'h00, hit32};
         accept_filter_pkg::MODE_16:     hits = {4'h0, hit16};
         accept_filter_pkg::MODE_8:      hits = hit8;
         accept_filter_pkg::MODE_CLOSED: hits = 8'h00;
      endcase
   end
   wire       accept_w = eval_q && |hits;
   wire [2:0] hit_w    = lowest_set(hits);
   wire       drop_w   = eval_q && !(|hits);

   // ==========================================
   // receive path: background then foreground
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         bg_ident_q <= 32'h0000_0000;
         bg_ext_q   <= 1'b0;
         eval_q     <= 1'b0;
      end else begin
         eval_q <= frame_valid_in;
         if (frame_valid_in) begin
            bg_ident_q <= frame_ident_in;
            bg_ext_q   <= frame_extended_in;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rx_foreground_ident_out <= 32'h0000_0000;
         rx_foreground_ext_out   <= 1'b0;
         filter_hit_index_out    <= `HIT_RST;
         rx_accept_out           <= 1'b0;
      end else begin
         rx_accept_out <= accept_w;
         if (accept_w) begin
            rx_foreground_ident_out <= bg_ident_q;
            rx_foreground_ext_out   <= bg_ext_q;
            filter_hit_index_out    <= hit_w;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         mode_q <= accept_filter_pkg::accept_mode_t'(`MODE_RST);
      end else if (wr_mode) begin
         mode_q <= accept_filter_pkg::accept_mode_t'(pwdata_in[`MODE_LSB +: 2]);
      end
   end

   // ==========================================
   // interrupts: read of status clears it, a new event wins
   // only the bits the read reported are cleared; a flag raised while the read was
   // in flight would otherwise be lost
   wire [1:0] stat_clr   = clr_stat ? prdata_out[1:0] : 2'h0;
   wire [1:0] irq_mask_d = (wr_done && idx == `IDX_IRQ_MASK) ? pwdata_in[1:0] : irq_mask_q;
   assign stat_d = (stat_q & ~stat_clr) | {drop_w, accept_w};
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         stat_q     <= 2'h0;
         irq_mask_q <= `IRQ_MASK_RST;
         irq_out    <= 1'b0;
      end else begin
         stat_q     <= stat_d;
         irq_mask_q <= irq_mask_d;
         irq_out    <= |(stat_d & irq_mask_d);
      end
   end

   // ==========================================
   // checks
   property p_closed;
      @(posedge clock_in) disable iff (rst_in)
      eval_q && mode_q == accept_filter_pkg::MODE_CLOSED
      |=> !rx_accept_out && $stable(rx_foreground_ident_out);
   endproperty
   a_closed: assert property (p_closed) else $error("closed filter accepted");

   property p_fg_hit;
      @(posedge clock_in) disable iff (rst_in)
      accept_w |=> rx_foreground_ident_out == $past(bg_ident_q)
                   && filter_hit_index_out == $past(hit_w);
   endproperty
   a_fg_hit: assert property (p_fg_hit) else $error("hit index not tied to frame");

   property p_mode_lock;
      @(posedge clock_in) disable iff (rst_in)
      wr_done && idx == `IDX_ACC_CTRL && !init_mode |=> $stable(mode_q);
   endproperty
   a_mode_lock: assert property (p_mode_lock) else $error("mode written outside init");

   property p_rsv_zero;
      @(posedge clock_in) disable iff (rst_in)
      bus_q == accept_filter_pkg::BUS_FETCH && (idx == `IDX_RSV_A || idx == `IDX_RSV_B)
      |=> prdata_out == 32'h0000_0000 && pready_out;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");

   property p_rx_err;
      @(posedge clock_in) disable iff (rst_in)
      bus_q == accept_filter_pkg::BUS_FETCH && !pwrite_in && idx == `IDX_RX_ERR
      && $past(count_mode)
      |=> prdata_out == {24'h000000, $past(rx_err_count_in, 2)};
   endproperty
   a_rx_err: assert property (p_rx_err) else $error("rx error count readout wrong");

   property p_tx_err;
      @(posedge clock_in) disable iff (rst_in)
      bus_q == accept_filter_pkg::BUS_FETCH && !pwrite_in && idx == `IDX_TX_ERR
      && $past(count_mode)
      |=> prdata_out == {24'h000000, $past(tx_err_count_in, 2)} ##1 !pready_out;
   endproperty
   a_tx_err: assert property (p_tx_err) else $error("tx error count readout wrong");

   property p_signal;
      @(posedge clock_in) disable iff (rst_in)
      rx_accept_out |-> $past(eval_q) && stat_q[`STAT_ACCEPT];
   endproperty
   a_signal: assert property (p_signal) else $error("accept without frame");

   property p_drop;
      @(posedge clock_in) disable iff (rst_in)
      drop_w |=> !rx_accept_out && stat_q[`STAT_DROP] && $stable(filter_hit_index_out);
   endproperty
   a_drop: assert property (p_drop) else $error("rejected frame was signalled");

   property p_byte8;
      @(posedge clock_in) disable iff (rst_in)
      eval_q && mode_q == accept_filter_pkg::MODE_8
      && ((id_b[0] ^ code_b[0]) & ~mask_b[0]) == 8'h00
      |=> rx_accept_out && filter_hit_index_out == 3'h0;
   endproperty
   a_byte8: assert property (p_byte8) else $error("8-bit filter 0 missed");

   property p_std32;
      @(posedge clock_in) disable iff (rst_in)
      eval_q && mode_q == accept_filter_pkg::MODE_32 && !bg_ext_q
      && ((id_b[0] ^ code_b[0]) & ~mask_b[0]) == 8'h00
      && ((id_b[1] ^ code_b[1]) & ~mask_b[1]) == 8'h00
      |=> rx_accept_out;
   endproperty
   a_std32: assert property (p_std32) else $error("standard frame missed");

endmodule : accept_filter

// File: sim/can_rx_source.sv
// receive path and error counters standing beside the acceptance filter
// assumes: one clock, the bench calls send and set_counts between edges
`timescale 1ns/100ps

module can_rx_source (
   input  wire logic        clock_in,
   output logic             frame_valid_out,
   output logic [31:0]      frame_ident_out,
   output logic             frame_extended_out,
   output logic [7:0]       rx_err_count_out,
   output logic [7:0]       tx_err_count_out
);
   initial begin
      frame_valid_out    = 1'b0;
      frame_ident_out    = 32'h0000_0000;
      frame_extended_out = 1'b0;
      rx_err_count_out   = 8'h00;
      tx_err_count_out   = 8'h00;
   end

   // ==========================================
   // frame strobe
   // lines invert after the strobe so a stale identifier never looks valid
   task automatic send(input logic [31:0] ident, input logic ext);
      @(posedge clock_in);
      frame_valid_out    <= 1'b1;
      frame_ident_out    <= ident;
      frame_extended_out <= ext;
      @(posedge clock_in);
      frame_valid_out    <= 1'b0;
      frame_ident_out    <= ~ident;
      frame_extended_out <= ~ext;
   endtask : send

   task automatic set_counts(input logic [7:0] rx, input logic [7:0] tx);
      @(posedge clock_in);
      rx_err_count_out <= rx;
      tx_err_count_out <= tx;
   endtask : set_counts
endmodule : can_rx_source

// File: sim/can_identifier_acceptance_filter_tb.sv
// self-checking bench of the acceptance filter over APB
// assumes: one wait state per APB transfer, receive path modelled by can_rx_source
`timescale 1ns/100ps
`include "accept_filter_cfg.svh"

module can_identifier_acceptance_filter_tb;
   logic        clock_in;
   logic        rst_in;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        fv;
   logic [31:0] fid;
   logic        fext;
   logic [7:0]  rxc;
   logic [7:0]  txc;
   logic        init_rq;
   logic        init_ak;
   logic        slp_rq;
   logic        slp_ak;
   logic        rx_accept_out;
   logic [31:0] fg_ident;
   logic        fg_ext;
   logic [2:0]  hit;
   logic        irq_out;
   logic [31:0] rd;
   logic        err;
   logic [31:0] fg_exp;
   logic [2:0]  hit_exp;
   logic        ext_exp;
   int          n_fail;
   int          total_checks;
   int          cycles;

   can_rx_source src (.clock_in(clock_in), .frame_valid_out(fv), .frame_ident_out(fid),
      .frame_extended_out(fext), .rx_err_count_out(rxc), .tx_err_count_out(txc));

   accept_filter uut (.clock_in(clock_in), .rst_in(rst_in), .paddr_in(paddr),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .frame_valid_in(fv), .frame_ident_in(fid), .frame_extended_in(fext),
      .rx_err_count_in(rxc), .tx_err_count_in(txc), .init_request_in(init_rq),
      .init_acknowledge_in(init_ak), .sleep_request_in(slp_rq),
      .sleep_acknowledge_in(slp_ak), .rx_accept_out(rx_accept_out),
      .rx_foreground_ident_out(fg_ident), .rx_foreground_ext_out(fg_ext),
      .filter_hit_index_out(hit), .irq_out(irq_out));

   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end

   // ==========================================
   // tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
      @(posedge clock_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge clock_in);
      penable <= 1'b1;
      do @(posedge clock_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      check(rd, exp);
   endtask : rd_chk

   task automatic set_mode(input logic [1:0] m);
      init_rq <= 1'b1;
      init_ak <= 1'b1;
      apb(1'b1, `IDX_ACC_CTRL, {26'h0, m, 4'h7});
      rd_chk(`IDX_ACC_CTRL, {26'h0, m, 1'b0, hit_exp});
      init_rq <= 1'b0;
      init_ak <= 1'b0;
   endtask : set_mode

   // counts strobes over four edges; one pulse only is allowed
   task automatic frame(input logic [31:0] id, input logic ext, input int acc,
                        input logic [2:0] exp_hit);
      int pulses;
      pulses = 0;
      src.send(id, ext);
      repeat (4) begin
         @(posedge clock_in);
         if (rx_accept_out === 1'b1) pulses++;
      end
      if (acc == 1) begin
         fg_exp  = id;
         hit_exp = exp_hit;
         ext_exp = ext;
      end
      check(pulses, acc);
      check(hit, exp_hit);
      check(fg_ident, fg_exp);
      check(fg_ext, ext_exp);
   endtask : frame

   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         stop_test();
      end
   end

   // ==========================================
   // sequence
   initial begin
      {rst_in, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {init_rq, init_ak, slp_rq, slp_ak} = 4'h0;
      {n_fail, total_checks, cycles, fg_exp, hit_exp, ext_exp} = '0;
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      rd_chk(`IDX_ACC_CTRL, 32'h0000_0000);
      apb(1'b1, `IDX_RSV_A, 32'h0000_00FF);
      rd_chk(`IDX_RSV_A, 32'h0000_0000);
      check(err, 1'b0);
      apb(1'b1, `IDX_RSV_B, 32'h0000_00FF);
      rd_chk(`IDX_RSV_B, 32'h0000_0000);
      rd_chk(6'h3F, 32'h0000_0000);
      check(err, 1'b1);
      apb(1'b1, `IDX_ACC_CTRL, 32'h0000_0030);
      rd_chk(`IDX_ACC_CTRL, 32'h0000_0000);
      src.set_counts(8'h5A, 8'hA5);
      slp_rq <= 1'b1;
      slp_ak <= 1'b1;
      apb(1'b1, `IDX_RX_ERR, 32'h0000_0011);
      rd_chk(`IDX_RX_ERR, 32'h0000_005A);
      apb(1'b1, `IDX_TX_ERR, 32'h0000_0022);
      rd_chk(`IDX_TX_ERR, 32'h0000_00A5);
      slp_rq <= 1'b0;
      slp_ak <= 1'b0;
      for (int i = 0; i < 8; i++) apb(1'b1, 6'(`IDX_CODE_BASE + i), 32'h11 * (i + 1));
      rd_chk(6'(`IDX_CODE_BASE + 2), 32'h0000_0033);
      apb(1'b1, `IDX_IRQ_MASK, 32'h0000_0003);
      rd_chk(`IDX_IRQ_MASK, 32'h0000_0003);
      frame(32'h5566_7788, 1'b1, 1, 3'h1);
      check(irq_out, 1'b1);
      rd_chk(`IDX_IRQ_STAT, 32'h0000_0001);
      @(posedge clock_in);
      check(irq_out, 1'b0);
      frame(32'h1122_3344, 1'b1, 1, 3'h0);
      frame(32'h1122_3345, 1'b1, 0, 3'h0);
      rd_chk(`IDX_IRQ_STAT, 32'h0000_0003);
      frame(32'h1122_0000, 1'b0, 1, 3'h0);
      check(fg_ext, 1'b0);
      apb(1'b1, 6'(`IDX_MASK_BASE + 3), 32'h0000_0001);
      rd_chk(6'(`IDX_MASK_BASE + 3), 32'h0000_0001);
      frame(32'h1122_3345, 1'b1, 1, 3'h0);
      apb(1'b1, 6'(`IDX_MASK_BASE + 3), 32'h0000_0000);
      set_mode(2'b01);
      frame(32'h3344_0000, 1'b0, 1, 3'h1);
      frame(32'h7788_FFFF, 1'b1, 1, 3'h3);
      rd_chk(`IDX_ACC_CTRL, 32'h0000_0013);
      set_mode(2'b10);
      frame(32'h7700_0000, 1'b1, 1, 3'h6);
      apb(1'b1, 6'(`IDX_CODE_BASE + 7), 32'h0000_0011);
      frame(32'h1100_0000, 1'b1, 1, 3'h0);
      set_mode(2'b11);
      apb(1'b1, `IDX_IRQ_STAT, 32'h0000_0000);
      rd_chk(`IDX_IRQ_STAT, 32'h0000_0001);
      apb(1'b1, `IDX_IRQ_MASK, 32'h0000_0000);
      frame(32'h1100_0000, 1'b1, 0, 3'h0);
      check(irq_out, 1'b0);
      rd_chk(`IDX_IRQ_STAT, 32'h0000_0002);
      stop_test();
   end
endmodule : can_identifier_acceptance_filter_tb
